// ### pkg/rgbpi_pkg.sv
// Constants and types for the parallel RGB pixel input port
package rgbpi_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_PORCH  = 8'h04;
    localparam logic [7:0] ADDR_WIN_X  = 8'h08;
    localparam logic [7:0] ADDR_WIN_Y  = 8'h0c;
    localparam logic [7:0] ADDR_TIMING = 8'h10;
    localparam logic [7:0] ADDR_COUNT  = 8'h14;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_STYLE_BIT  = 0;
    localparam int CTRL_FMT_LSB    = 4;
    localparam int CTRL_LAYOUT_BIT = 8;
    localparam int CTRL_EN_BIT     = 9;
    localparam int PORCH_VBP_LSB   = 0;
    localparam int PORCH_VFP_LSB   = 8;
    localparam int PORCH_HBP_LSB   = 16;
    localparam int PORCH_HFP_LSB   = 24;
    localparam int WIN_LO_LSB      = 0;
    localparam int WIN_HI_LSB      = 16;
    localparam int PORCH_W         = 6;
    localparam int POS_W           = 12;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_CTRL  = 32'h0000_0270;
    localparam logic [31:0] RST_PORCH = 32'h0000_0000;
    localparam logic [31:0] RST_WIN   = 32'h0fff_0000;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [3:0] FMT_24 = 4'h7;
    localparam logic [3:0] FMT_18 = 4'h6;
    localparam logic [3:0] FMT_16 = 4'h5;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] r;
        logic [7:0] g;
        logic [7:0] b;
    } rgbpi_rgb_t;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        rgbpi_rgb_t  rgb;
    } rgbpi_lbw_t;

endpackage

// ### verilog/rgbpi_sync.sv
// Two-flop synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module rgbpi_sync #(
    parameter int W = 1
) (
    // Clock
    input  wire logic         aclk,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge aclk) begin
                meta[i] <= d[i];
                q[i]    <= meta[i];
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ### verilog/rgbpi_port.sv
// Parallel RGB pixel input port with AXI4-Lite control registers
//
// Design decisions made here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module rgbpi_port (
    // Clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]            awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    // AXI4-Lite read
    input  wire logic [7:0]            araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [31:0]                rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    // Video pins
    input  wire logic                  dot_rate_clock,
    input  wire logic                  frame_sync,
    input  wire logic                  line_sync,
    input  wire logic                  pixel_valid,
    input  wire logic [23:0]           pixel_bus,
    // Line buffer write
    output logic                       lb_we,
    output rgbpi_pkg::rgbpi_lbw_t      lb
);
    import rgbpi_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [27:0] pins_s;
    logic        dclk_d;
    logic        fs_d;
    logic        ls_d;

    rgbpi_sync #(.W(28)) u_sync (
        .aclk (aclk),
        .d    ({dot_rate_clock, frame_sync, line_sync, pixel_valid, pixel_bus}),
        .q    (pins_s)
    );

    wire logic        dclk_s = pins_s[27];
    wire logic        fs_s   = pins_s[26];
    wire logic        ls_s   = pins_s[25];
    wire logic        val_s  = pins_s[24];
    wire logic [23:0] bus_s  = pins_s[23:0];
    wire logic        rise   = dclk_s & ~dclk_d;
    wire logic        fs_edge = rise & fs_s & ~fs_d;
    wire logic        ls_edge = rise & ls_s & ~ls_d;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dclk_d <= 1'b0;
            fs_d   <= 1'b0;
            ls_d   <= 1'b0;
        end else begin
            dclk_d <= dclk_s;
            if (rise) begin
                fs_d <= fs_s;
                ls_d <= ls_s;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [31:0] ctrl;
    logic [31:0] porch;
    logic [31:0] win_x;
    logic [31:0] win_y;
    logic [31:0] pix_count;
    logic [11:0] hlen;
    logic [11:0] vlen;

    wire logic       style  = ctrl[CTRL_STYLE_BIT];
    wire logic [3:0] fmt    = ctrl[CTRL_FMT_LSB +: 4];
    wire logic       layout = ctrl[CTRL_LAYOUT_BIT];
    wire logic       enable = ctrl[CTRL_EN_BIT];
    wire logic [11:0] vbp = {6'h00, porch[PORCH_VBP_LSB +: PORCH_W]};
    wire logic [11:0] vfp = {6'h00, porch[PORCH_VFP_LSB +: PORCH_W]};
    wire logic [11:0] hbp = {6'h00, porch[PORCH_HBP_LSB +: PORCH_W]};
    wire logic [11:0] hfp = {6'h00, porch[PORCH_HFP_LSB +: PORCH_W]};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    wire logic wr_go = awvalid & wvalid & ~bvalid;
    wire logic rd_go = arvalid & ~rvalid;

    assign awready = wr_go;
    assign wready  = wr_go;
    assign arready = ~rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl  <= RST_CTRL;
            porch <= RST_PORCH;
            win_x <= RST_WIN;
            win_y <= RST_WIN;
        end else if (wr_go) begin
            case (awaddr)
                ADDR_CTRL:  ctrl  <= merge(ctrl, wdata, wstrb);
                ADDR_PORCH: porch <= merge(porch, wdata, wstrb);
                ADDR_WIN_X: win_x <= merge(win_x, wdata, wstrb);
                ADDR_WIN_Y: win_y <= merge(win_y, wdata, wstrb);
                default:    ctrl  <= ctrl;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= (awaddr == ADDR_CTRL || awaddr == ADDR_PORCH ||
                       awaddr == ADDR_WIN_X || awaddr == ADDR_WIN_Y) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rresp  <= RESP_OKAY;
            case (araddr)
                ADDR_CTRL:   rdata <= ctrl;
                ADDR_PORCH:  rdata <= porch;
                ADDR_WIN_X:  rdata <= win_x;
                ADDR_WIN_Y:  rdata <= win_y;
                ADDR_TIMING: rdata <= {4'h0, hlen, 4'h0, vlen};
                ADDR_COUNT:  rdata <= pix_count;
                default: begin
                    rdata <= 32'h0000_0000;
                    rresp <= RESP_SLVERR;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Raster counters
    // ----------------------------------------------------------------
    logic [11:0] hcnt;
    logic [11:0] vcnt;
    logic [11:0] xval;

    wire logic [11:0] hpos = ls_edge ? 12'h000 : hcnt + 12'h001;
    wire logic [11:0] xpos = ls_edge ? 12'h000 : xval;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hcnt <= 12'h000;
            hlen <= 12'h000;
            xval <= 12'h000;
        end else if (rise) begin
            hcnt <= hpos;
            if (ls_edge) begin
                hlen <= hcnt + 12'h001;
            end
            xval <= (val_s && !style) ? xpos + 12'h001 : xpos;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            vcnt <= 12'h000;
            vlen <= 12'h000;
        end else if (fs_edge) begin
            vcnt <= 12'h000;
            vlen <= vcnt;
        end else if (ls_edge) begin
            vcnt <= vcnt + 12'h001;
        end
    end

    // ----------------------------------------------------------------
    // Active area, window and capture
    // ----------------------------------------------------------------
    wire logic h_act = (hpos >= hbp) && (hpos + hfp < hlen);
    wire logic v_act = (vcnt >= vbp) && (vcnt + vfp < vlen);
    wire logic [11:0] cx = style ? hpos - hbp : xpos;
    wire logic [11:0] cy = style ? vcnt - vbp : vcnt;
    wire logic in_win = (cx >= win_x[WIN_LO_LSB +: POS_W]) && (cx <= win_x[WIN_HI_LSB +: POS_W]) &&
                        (cy >= win_y[WIN_LO_LSB +: POS_W]) && (cy <= win_y[WIN_HI_LSB +: POS_W]);
    wire logic fmt_ok = (fmt == FMT_24) || (fmt == FMT_18) || (fmt == FMT_16);
    // Style 0 gates by strobe, style 1 by porch counters
    wire logic take = style ? (h_act && v_act) : val_s;
    wire logic cap  = rise && enable && fmt_ok && in_win && take;

    function automatic rgbpi_rgb_t decode(input logic [3:0] f, input logic lay,
                                          input logic [23:0] d);
        rgbpi_rgb_t c;
        c = '0;
        case (f)
            FMT_24: c = '{r: d[23:16], g: d[15:8], b: d[7:0]};
            FMT_18: begin
                if (lay) begin
                    c = '{r: {d[17:12], 2'h0}, g: {d[11:6], 2'h0}, b: {d[5:0], 2'h0}};
                end else begin
                    c = '{r: {d[21:16], 2'h0}, g: {d[13:8], 2'h0}, b: {d[5:0], 2'h0}};
                end
            end
            FMT_16:  c = '{r: {d[20:16], 3'h0}, g: {d[13:8], 2'h0}, b: {d[4:0], 3'h0}};
            default: c = '0;
        endcase
        return c;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lb_we     <= 1'b0;
            lb        <= '0;
            pix_count <= 32'h0000_0000;
        end else begin
            lb_we <= cap;
            if (cap) begin
                lb        <= '{x: cx, y: cy, rgb: decode(fmt, layout, bus_s)};
                pix_count <= pix_count + 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_strobe_gate;
        @(posedge aclk) disable iff (!aresetn)
        (rise && !style && !val_s) |=> !lb_we;
    endproperty
    a_strobe_gate: assert property (p_strobe_gate) else $error("write without strobe");

    property p_strobe_needs_valid;
        @(posedge aclk) disable iff (!aresetn)
        (lb_we && !$past(style)) |-> $past(val_s);
    endproperty
    a_strobe_needs_valid: assert property (p_strobe_needs_valid) else $error("strobe low");

    property p_sync_ignores_valid;
        @(posedge aclk) disable iff (!aresetn)
        (rise && style && enable && fmt_ok && in_win && h_act && v_act && !val_s) |=> lb_we;
    endproperty
    a_sync_ignores_valid: assert property (p_sync_ignores_valid) else $error("sync write lost");

    property p_hporch;
        @(posedge aclk) disable iff (!aresetn)
        (lb_we && $past(style)) |-> ($past(hpos) >= $past(hbp)) &&
                                    ($past(hpos) + $past(hfp) < $past(hlen));
    endproperty
    a_hporch: assert property (p_hporch) else $error("pixel outside horizontal porch");

    property p_vporch;
        @(posedge aclk) disable iff (!aresetn)
        (lb_we && $past(style)) |-> ($past(vcnt) >= $past(vbp)) &&
                                    ($past(vcnt) + $past(vfp) < $past(vlen));
    endproperty
    a_vporch: assert property (p_vporch) else $error("pixel outside vertical porch");

    property p_fmt24;
        @(posedge aclk) disable iff (!aresetn)
        (lb_we && $past(fmt) == FMT_24) |-> lb.rgb == $past(bus_s);
    endproperty
    a_fmt24: assert property (p_fmt24) else $error("24-bit mapping wrong");

    property p_fmt18;
        @(posedge aclk) disable iff (!aresetn)
        (lb_we && $past(fmt) == FMT_18) |->
            ($past(layout) ? lb.rgb.r[7:2] == $past(bus_s[17:12])
                           : lb.rgb.r[7:2] == $past(bus_s[21:16])) &&
            lb.rgb.b[7:2] == $past(bus_s[5:0]);
    endproperty
    a_fmt18: assert property (p_fmt18) else $error("18-bit mapping wrong");

    property p_fmt16;
        @(posedge aclk) disable iff (!aresetn)
        (lb_we && $past(fmt) == FMT_16) |->
            lb.rgb.r[7:3] == $past(bus_s[20:16]) && lb.rgb.g[7:2] == $past(bus_s[13:8]) &&
            lb.rgb.b[7:3] == $past(bus_s[4:0]);
    endproperty
    a_fmt16: assert property (p_fmt16) else $error("16-bit mapping wrong");

    property p_window;
        @(posedge aclk) disable iff (!aresetn)
        lb_we |-> (lb.x >= $past(win_x[WIN_LO_LSB +: POS_W])) &&
                  (lb.x <= $past(win_x[WIN_HI_LSB +: POS_W])) &&
                  (lb.y >= $past(win_y[WIN_LO_LSB +: POS_W])) &&
                  (lb.y <= $past(win_y[WIN_HI_LSB +: POS_W]));
    endproperty
    a_window: assert property (p_window) else $error("write outside window");

    property p_style;
        @(posedge aclk) disable iff (!aresetn)
        (rise && style && !(h_act && v_act)) |=> !lb_we;
    endproperty
    a_style: assert property (p_style) else $error("sync-only wrote blanking pixel");

    property p_line_count;
        @(posedge aclk) disable iff (!aresetn)
        (ls_edge && !fs_edge) |=> vcnt == $past(vcnt) + 12'h001 && hcnt == 12'h000;
    endproperty
    a_line_count: assert property (p_line_count) else $error("raster count wrong");
endmodule
`default_nettype wire

// ### bench/rgbpi_host.sv
// Host display controller model driving the parallel video pins
`timescale 1ns/1ps
`default_nettype none
module rgbpi_host (
    // Video pins
    output logic        dot_rate_clock,
    output logic        frame_sync,
    output logic        line_sync,
    output logic        pixel_valid,
    output logic [23:0] pixel_bus
);
    // ----------------------------------------------------------------
    // Free-running dot clock, 800 ns
    // ----------------------------------------------------------------
    initial begin
        dot_rate_clock = 1'b0;
        frame_sync = 1'b0;
        line_sync = 1'b0;
        pixel_valid = 1'b0;
        pixel_bus = 24'h000000;
        #137;
        forever #400 dot_rate_clock = ~dot_rate_clock;
    end

    function automatic logic [23:0] pix(input int k);
        logic [7:0] b;
        b = k[7:0];
        return 24'h5a3cc3 ^ {b * 8'h13, b * 8'h29, b * 8'h47};
    endfunction

    // Blanking: strobe low, bus flips every dot period
    task automatic blank();
        pixel_valid = 1'b0;
        pixel_bus = ~pixel_bus;
    endtask

    // One dot period of frame sync, clear of any line sync
    task automatic frame();
        @(negedge dot_rate_clock);
        line_sync = 1'b0;
        frame_sync = 1'b1;
        blank();
        @(negedge dot_rate_clock);
        frame_sync = 1'b0;
        blank();
    endtask

    // Line of len dot periods: sync one period, bus per dm, strobe per vm
    task automatic line(input int len, input logic [31:0] dm, input logic [31:0] vm);
        for (int k = 0; k < len; k++) begin
            @(negedge dot_rate_clock);
            line_sync = (k == 0);
            pixel_valid = vm[k];
            pixel_bus = dm[k] ? pix(k) : ~pixel_bus;
        end
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            @(negedge dot_rate_clock);
            line_sync = 1'b0;
            blank();
        end
    endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking testbench for the parallel RGB pixel input port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rgbpi_pkg::*;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, lb_we;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        dot_rate_clock, frame_sync, line_sync, pixel_valid;
    logic [23:0] pixel_bus;
    rgbpi_lbw_t  lb;
    rgbpi_lbw_t  q [$];
    int          n_errors, checks;

    rgbpi_port i_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .dot_rate_clock(dot_rate_clock), .frame_sync(frame_sync), .line_sync(line_sync),
        .pixel_valid(pixel_valid), .pixel_bus(pixel_bus), .lb_we(lb_we), .lb(lb)
    );
    rgbpi_host i_host (
        .dot_rate_clock(dot_rate_clock), .frame_sync(frame_sync), .line_sync(line_sync),
        .pixel_valid(pixel_valid), .pixel_bus(pixel_bus)
    );

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        if (lb_we === 1'b1) q.push_back(lb);
    end

    // ----------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------
    task print_verdict();
        if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task chk_pix(input rgbpi_lbw_t got, input rgbpi_lbw_t exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task guard(input int n);
        if (n >= 100) begin
            n_errors++;
            print_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 100);
        bready <= 1'b0;
        guard(n);
        chk_reg({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 100);
        rready <= 1'b0;
        guard(n);
        chk_reg(rdata, exp);
        chk_reg({30'h0, rresp}, {30'h0, er});
    endtask

    function automatic rgbpi_rgb_t exp_rgb(input logic [3:0] f, input logic l, input logic [23:0] d);
        if (f == FMT_24) return d;
        if (f == FMT_18 && l) return {d[17:12], 2'h0, d[11:6], 2'h0, d[5:0], 2'h0};
        if (f == FMT_18) return {d[21:16], 2'h0, d[13:8], 2'h0, d[5:0], 2'h0};
        return {d[20:16], 3'h0, d[13:8], 2'h0, d[4:0], 3'h0};
    endfunction

    // Expected writes of one line: active positions in am, x window xlo..xhi
    task automatic chk_line(input int len, input logic [31:0] am, input int y, input int xlo,
                            input int xhi, input logic [3:0] f, input logic l);
        int         x;
        rgbpi_lbw_t e, g;
        x = 0;
        for (int k = 0; k < len; k++) begin
            if (am[k]) begin
                if (x >= xlo && x <= xhi) begin
                    e = {x[11:0], y[11:0], exp_rgb(f, l, i_host.pix(k))};
                    g = 'x;
                    if (q.size() > 0) g = q.pop_front();
                    chk_pix(g, e);
                end
                x++;
            end
        end
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(ADDR_CTRL, RST_CTRL, RESP_OKAY);
        rd(ADDR_PORCH, RST_PORCH, RESP_OKAY);
        rd(ADDR_WIN_X, RST_WIN, RESP_OKAY);
        rd(ADDR_WIN_Y, RST_WIN, RESP_OKAY);
        rd(8'h18, 32'h0, RESP_SLVERR);
        wr(ADDR_TIMING, 32'h1, RESP_SLVERR);
        wr(8'h1c, 32'h1, RESP_SLVERR);
    endtask

    task automatic t_sync();
        wr(ADDR_PORCH, 32'h0203_0202, RESP_OKAY);
        rd(ADDR_PORCH, 32'h0203_0202, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0000_0271, RESP_OKAY);
        i_host.frame();
        repeat (6) i_host.line(16, 32'h3ff8, 32'hc007);
        q.delete();
        i_host.frame();
        repeat (6) i_host.line(16, 32'h3ff8, 32'hc007);
        i_host.idle(2);
        chk_line(16, 32'h3ff8, 0, 0, 4095, FMT_24, 1'b0);
        chk_line(16, 32'h3ff8, 1, 0, 4095, FMT_24, 1'b0);
        chk_reg(32'(q.size()), 32'h0);
        rd(ADDR_TIMING, 32'h0010_0006, RESP_OKAY);
    endtask

    task automatic t_fmt();
        logic [31:0] c [4] = '{32'h270, 32'h260, 32'h360, 32'h250};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CTRL, c[i], RESP_OKAY);
            i_host.frame();
            i_host.line(12, 32'h0db6, 32'h0db6);
            i_host.idle(2);
            chk_line(12, 32'h0db6, 1, 0, 4095, c[i][7:4], c[i][8]);
        end
        chk_reg(32'(q.size()), 32'h0);
    endtask

    task automatic t_refuse();
        logic [31:0] c [3] = '{32'h070, 32'h230, 32'h280};
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, c[i], RESP_OKAY);
            i_host.frame();
            i_host.line(8, 32'hff, 32'hff);
            i_host.idle(2);
            chk_reg(32'(q.size()), 32'h0);
        end
        wr(ADDR_CTRL, 32'h270, RESP_OKAY);
        wr(ADDR_WIN_X, 32'h0004_0002, RESP_OKAY);
        i_host.frame();
        i_host.line(8, 32'hff, 32'hff);
        i_host.idle(2);
        chk_line(8, 32'hff, 1, 2, 4, FMT_24, 1'b0);
        chk_reg(32'(q.size()), 32'h0);
        wr(ADDR_WIN_X, RST_WIN, RESP_OKAY);
        // Accepted pixels so far: 22 sync-only, 32 format, 3 windowed
        rd(ADDR_COUNT, 32'h0000_0039, RESP_OKAY);
    endtask

    initial begin
        n_errors = 0;
        checks = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'h0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_sync();
        t_fmt();
        t_refuse();
        print_verdict();
    end
endmodule
`default_nettype wire
